// *** rtl/sic_pkg.sv ***
// Constants, register map and types for the subroutine and interrupt controller
// How it works
// R1 - A true-condition call runs the numbered routine, then resumes after the call.
// R2 - Calls nest through a return stack of sixteen levels.
// R3 - Self-calls and nesting past sixteen levels raise the error flag.
// R4 - Calling an undefined routine number raises the error flag.
// R5 - No call executes while the error flag is set.
// R6 - Designator 0 to 3 picks an input module, 4 the scheduled interrupt.
// R7 - Software gives a word address, never an immediate, for control code 2.
// R8 - Only the low eight inputs of each module make requests.
// R9 - Module input vectors to routine module times eight plus bit.
// R10 - Code 0 masks inputs whose bit is one and unmasks the rest.
// R11 - Masked requests stay latched and run once unmasked unless cleared.
// R12 - Every module input starts masked after reset.
// R13 - Code 1 discards latched requests whose control bit is one.
// R14 - Code 2 returns the module's eight mask bits.
// R15 - Scheduled interrupt runs routine 99 at its own period.
// R16 - Scheduled codes: 0 sets period, 1 first delay, 2 reads period.
// R17 - Software programs both period and first delay before relying on it.
// R18 - First delay is four BCD digits, 00.01 to 99.99 seconds.
// R19 - Zero delay disables; writing the delay restarts the wait at once.
// R20 - Bad control code, control data or designator raises the error flag.
// R21 - Module routines never overlap; lowest routine number wins ties.
// R22 - Scheduled interrupt preempts a module routine and then resumes it.
// R23 - A request latches on an input's rising edge until dispatched or cleared.
package sic_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CALL = 8'h04;
   localparam logic [7:0] OFS_RET = 8'h08;
   localparam logic [7:0] OFS_RESUME = 8'h0c;
   localparam logic [7:0] OFS_DEFINE = 8'h10;
   localparam logic [7:0] OFS_INTCTL = 8'h14;
   localparam logic [7:0] OFS_RESULT = 8'h18;
   localparam logic [7:0] OFS_ERRCLR = 8'h1c;
   localparam logic [7:0] OFS_PENDING = 8'h20;
   localparam logic [7:0] OFS_MASK = 8'h24;
   // Field positions
   localparam int CALL_COND_BIT = 31;
   localparam int CALL_NUM_LSB = 16;
   localparam int DEF_SET_BIT = 8;
   localparam int ICTL_DES_LSB = 16;
   localparam int ICTL_CODE_LSB = 20;
   localparam int ICTL_IMM_BIT = 24;
   // Sizes and limits
   localparam int NUM_MODULES = 4;
   localparam int MOD_INPUTS = 8;
   localparam int MOD_WIDTH = 16;
   localparam int STACK_DEPTH = 16;
   localparam logic [6:0] MAX_ROUTINE = 7'h63;
   localparam logic [6:0] SCHED_ROUTINE = 7'h63;
   localparam logic [2:0] DES_SCHED = 3'h4;
   localparam logic [1:0] CODE_SET = 2'h0;
   localparam logic [1:0] CODE_CLEAR = 2'h1;
   localparam logic [1:0] CODE_READ = 2'h2;
   // Reset values
   localparam logic [31:0] MASK_RESET = 32'hffffffff;
   localparam logic [15:0] TIME_RESET = 16'h0000;
   // Timing: one schedule tick is 0.01 s
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS = 10000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
   // Context kinds of the running code, one-hot
   typedef enum logic [3:0] {
      SIC_MAIN = 4'b0001,
      SIC_CALL = 4'b0010,
      SIC_MOD = 4'b0100,
      SIC_SCHED = 4'b1000
   } sic_kind_t;
endpackage

// *** rtl/sic_prio.sv ***
// Lowest-index request picker for module interrupts
`timescale 1ns/1ps
module sic_prio (
   input wire logic [31:0] req,
   output logic valid,
   output logic [4:0] idx
);
   // Scan downward so the lowest set bit is the last to win
   always_comb begin
      valid = 1'b0;
      idx = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            idx = 5'(i);
         end
      end
   end
endmodule // sic_prio

// *** rtl/sic_top.sv ***
// Subroutine call and return engine with module and scheduled interrupt control
`timescale 1ns/1ps
module sic_top #(
   parameter int TICK_CYCLES = sic_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [63:0] module_in,
   input wire logic [15:0] seq_pc,
   output logic error_flag,
   output logic [6:0] cur_routine,
   output logic int_dispatch
);
   // Bus decode
   logic done;
   logic wr_call, wr_ret, wr_def, wr_ictl, wr_eclr;
   logic [31:0] next_rdata;
   logic next_err_resp;
   // Context and stack
   logic [26:0] stack_mem [sic_pkg::STACK_DEPTH];
   logic [4:0] depth;
   sic_pkg::sic_kind_t cur_kind;
   logic [15:0] resume_pc;
   logic mod_busy, sch_busy;
   logic [99:0] defined;
   // Call and control decode
   logic call_cond, call_err, call_ok, ret_err, stack_full;
   logic [6:0] call_num;
   logic [2:0] des;
   logic [1:0] code;
   logic ictl_err, ictl_ok, def_err;
   // Interrupt inputs
   logic [63:0] in_meta, in_sync, in_prev;
   logic [31:0] in_low, in_prev_low, latch, mask, rise, clr_req, eligible;
   logic prio_valid;
   logic [4:0] prio_idx;
   logic start_sched, start_mod, bus_cmd;
   // Scheduler
   logic [15:0] period, delay;
   logic [31:0] prescale;
   logic [13:0] tick_left;
   logic sched_armed, sched_pend, tick;
   logic [31:0] result;

   // Four BCD digits as a binary count of 0.01 s ticks
   function automatic logic [13:0] bcd_bin(input logic [15:0] b);
      bcd_bin = 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
   endfunction

   // True when every nibble is a decimal digit
   function automatic logic bcd_ok(input logic [15:0] b);
      bcd_ok = (b[15:12] <= 4'h9) && (b[11:8] <= 4'h9) && (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
   endfunction

   // Known offsets; anything else answers with pslverr
   function automatic logic addr_ok(input logic [7:0] a);
      if (a == sic_pkg::OFS_STATUS || a == sic_pkg::OFS_CALL || a == sic_pkg::OFS_RET) begin
         addr_ok = 1'b1;
      end else if (a == sic_pkg::OFS_RESUME || a == sic_pkg::OFS_DEFINE || a == sic_pkg::OFS_INTCTL) begin
         addr_ok = 1'b1;
      end else if (a == sic_pkg::OFS_RESULT || a == sic_pkg::OFS_ERRCLR) begin
         addr_ok = 1'b1;
      end else if (a == sic_pkg::OFS_PENDING || a == sic_pkg::OFS_MASK) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   endfunction

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   // A write takes effect only at the edge that completes the transfer
   assign done = psel & penable & pready;
   assign wr_call = done & pwrite & (paddr == sic_pkg::OFS_CALL);
   assign wr_ret = done & pwrite & (paddr == sic_pkg::OFS_RET);
   assign wr_def = done & pwrite & (paddr == sic_pkg::OFS_DEFINE);
   assign wr_ictl = done & pwrite & (paddr == sic_pkg::OFS_INTCTL);
   assign wr_eclr = done & pwrite & (paddr == sic_pkg::OFS_ERRCLR);

   // Read mux, loaded during the wait cycle
   always_comb begin
      next_rdata = 32'h00000000;
      next_err_resp = ~addr_ok(paddr);
      if (paddr == sic_pkg::OFS_STATUS) begin
         next_rdata = {11'h000, sched_pend, sch_busy, mod_busy, cur_kind, cur_routine, depth, 1'b0, error_flag};
      end else if (paddr == sic_pkg::OFS_RESUME) begin
         next_rdata = {16'h0000, resume_pc};
      end else if (paddr == sic_pkg::OFS_RESULT) begin
         next_rdata = result;
      end else if (paddr == sic_pkg::OFS_PENDING) begin
         next_rdata = latch;
      end else if (paddr == sic_pkg::OFS_MASK) begin
         next_rdata = mask;
      end
   end

   // Read data and error response stand from the wait cycle through completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel & penable & ~pready) begin
         prdata <= pwrite ? 32'h00000000 : next_rdata;
         pslverr <= next_err_resp;
      end
   end

   // Call checks
   assign call_cond = pwdata[sic_pkg::CALL_COND_BIT];
   assign call_num = pwdata[sic_pkg::CALL_NUM_LSB +: 7];
   assign stack_full = (depth == 5'(sic_pkg::STACK_DEPTH));
   always_comb begin
      call_err = 1'b0;
      if (call_num > sic_pkg::MAX_ROUTINE) begin
         call_err = 1'b1;
      end else if (!defined[call_num]) begin
         call_err = 1'b1; // [R4]
      end else if (cur_kind != sic_pkg::SIC_MAIN && call_num == cur_routine) begin
         call_err = 1'b1; // [R3]
      end else if (stack_full) begin
         call_err = 1'b1; // [R2] [R3]
      end
   end
   // A set error flag blocks the call without re-raising the flag
   assign call_ok = wr_call & call_cond & ~error_flag & ~call_err; // [R1] [R5]
   assign ret_err = wr_ret & (depth == 5'h00);

   // Interrupt control decode
   assign des = pwdata[sic_pkg::ICTL_DES_LSB +: 3];
   assign code = pwdata[sic_pkg::ICTL_CODE_LSB +: 2];
   always_comb begin
      ictl_err = 1'b0;
      if (des > sic_pkg::DES_SCHED || code > sic_pkg::CODE_READ) begin
         ictl_err = 1'b1; // [R6] [R20]
      end else if (code == sic_pkg::CODE_READ && pwdata[sic_pkg::ICTL_IMM_BIT]) begin
         ictl_err = 1'b1; // [R7] [R20]
      end else if (des == sic_pkg::DES_SCHED && code != sic_pkg::CODE_READ && !bcd_ok(pwdata[15:0])) begin
         ictl_err = 1'b1; // [R18] [R20]
      end
   end
   assign ictl_ok = wr_ictl & ~ictl_err;
   assign def_err = wr_def & (pwdata[6:0] > sic_pkg::MAX_ROUTINE);

   // Error flag: a new fault in the clearing cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_flag <= 1'b0;
      end else begin
         error_flag <= (wr_call & call_cond & ~error_flag & call_err) | ret_err | (wr_ictl & ictl_err) | def_err
                       | (error_flag & ~wr_eclr); // [R3] [R4] [R20]
      end
   end

   // Table of routine numbers that have a start marker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         defined <= '0;
      end else if (wr_def && !def_err) begin
         defined[pwdata[6:0]] <= pwdata[sic_pkg::DEF_SET_BIT];
      end
   end

   // Two-stage synchronisers for the module input pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_meta <= '0;
         in_sync <= '0;
         in_prev <= '0;
      end else begin
         in_meta <= module_in;
         in_sync <= in_meta;
         in_prev <= in_sync;
      end
   end

   // Pick the low eight inputs of every module
   genvar m;
   generate
      for (m = 0; m < sic_pkg::NUM_MODULES; m++) begin : g_mod
         assign in_low[m*8 +: 8] = in_sync[m*sic_pkg::MOD_WIDTH +: sic_pkg::MOD_INPUTS]; // [R8] [R9]
         assign in_prev_low[m*8 +: 8] = in_prev[m*sic_pkg::MOD_WIDTH +: sic_pkg::MOD_INPUTS]; // [R8]
      end
   endgenerate
   assign rise = in_low & ~in_prev_low;

   // Requests cleared by the clear code or by being dispatched
   always_comb begin
      clr_req = 32'h00000000;
      if (ictl_ok && des != sic_pkg::DES_SCHED && code == sic_pkg::CODE_CLEAR) begin
         clr_req[{des[1:0], 3'b000} +: 8] = pwdata[7:0]; // [R13]
      end
      if (start_mod) begin
         clr_req[prio_idx] = 1'b1;
      end
   end

   // Latches record even masked inputs; a new edge beats a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch <= 32'h00000000;
      end else begin
         latch <= rise | (latch & ~clr_req); // [R11] [R23]
      end
   end

   // Masks start set; code 0 loads one module's byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= sic_pkg::MASK_RESET; // [R12]
      end else if (ictl_ok && des != sic_pkg::DES_SCHED && code == sic_pkg::CODE_SET) begin
         mask[{des[1:0], 3'b000} +: 8] <= pwdata[7:0]; // [R10]
      end
   end

   // Read-back word for code 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= 32'h00000000;
      end else if (ictl_ok && code == sic_pkg::CODE_READ) begin
         if (des == sic_pkg::DES_SCHED) begin
            result <= {16'h0000, period}; // [R16]
         end else begin
            result <= {24'h000000, mask[{des[1:0], 3'b000} +: 8]}; // [R14]
         end
      end
   end

   // Period and first delay, kept as written BCD
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period <= sic_pkg::TIME_RESET;
         delay <= sic_pkg::TIME_RESET;
      end else if (ictl_ok && des == sic_pkg::DES_SCHED) begin
         if (code == sic_pkg::CODE_SET) begin
            period <= pwdata[15:0]; // [R16]
         end else if (code == sic_pkg::CODE_CLEAR) begin
            delay <= pwdata[15:0]; // [R16] [R18]
         end
      end
   end

   // Free-running 0.01 s prescaler, restarted by a delay write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 32'h00000000;
      end else if (ictl_ok && des == sic_pkg::DES_SCHED && code == sic_pkg::CODE_CLEAR) begin
         prescale <= 32'h00000000; // [R19]
      end else if (prescale == 32'(TICK_CYCLES - 1)) begin
         prescale <= 32'h00000000;
      end else begin
         prescale <= prescale + 32'h00000001;
      end
   end
   assign tick = (prescale == 32'(TICK_CYCLES - 1));

   // Countdown to the next scheduled run; runs apart from the program scan
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_left <= 14'h0000;
         sched_armed <= 1'b0;
      end else if (ictl_ok && des == sic_pkg::DES_SCHED && code == sic_pkg::CODE_CLEAR) begin
         tick_left <= bcd_bin(pwdata[15:0]); // [R19]
         sched_armed <= (pwdata[15:0] != 16'h0000); // [R19]
      end else if (sched_armed && tick) begin
         if (tick_left <= 14'h0001) begin
            tick_left <= bcd_bin(period); // [R15]
            sched_armed <= (period != 16'h0000); // Without a period it fires once and stops
         end else begin
            tick_left <= tick_left - 14'h0001;
         end
      end
   end

   // Pending scheduled run; the expiry wins over its own dispatch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sched_pend <= 1'b0;
      end else begin
         sched_pend <= (sched_armed & tick & (tick_left <= 14'h0001)) | (sched_pend & ~start_sched); // [R15]
      end
   end

   // Dispatch gating: bus commands go first so the stack has one writer per cycle
   assign eligible = latch & ~mask; // [R11]
   sic_prio u_prio (
      .req(eligible),
      .valid(prio_valid),
      .idx(prio_idx)
   );
   assign bus_cmd = wr_call | wr_ret;
   assign start_sched = sched_pend & ~sch_busy & ~stack_full & ~bus_cmd; // [R22]
   assign start_mod = prio_valid & ~mod_busy & ~sch_busy & ~stack_full & ~bus_cmd & ~start_sched; // [R21]

   // Return stack storage
   always_ff @(posedge pclk) begin
      if (call_ok) begin
         stack_mem[depth[3:0]] <= {cur_kind, cur_routine, seq_pc}; // [R2]
      end else if (start_sched || start_mod) begin
         stack_mem[depth[3:0]] <= {cur_kind, cur_routine, seq_pc}; // [R22]
      end
   end

   // Context: what runs now, nesting depth and the point to resume at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth <= 5'h00;
         cur_kind <= sic_pkg::SIC_MAIN;
         cur_routine <= 7'h00;
         resume_pc <= 16'h0000;
         int_dispatch <= 1'b0;
      end else begin
         int_dispatch <= start_sched | start_mod;
         if (call_ok) begin
            depth <= depth + 5'h01; // [R2]
            cur_kind <= sic_pkg::SIC_CALL;
            cur_routine <= call_num; // [R1]
         end else if (wr_ret && !ret_err) begin
            depth <= depth - 5'h01;
            cur_kind <= sic_pkg::sic_kind_t'(stack_mem[depth[3:0] - 4'h1][26:23]); // [R22]
            cur_routine <= stack_mem[depth[3:0] - 4'h1][22:16]; // [R1]
            resume_pc <= stack_mem[depth[3:0] - 4'h1][15:0]; // [R1]
         end else if (start_sched) begin
            depth <= depth + 5'h01;
            cur_kind <= sic_pkg::SIC_SCHED;
            cur_routine <= sic_pkg::SCHED_ROUTINE; // [R15]
         end else if (start_mod) begin
            depth <= depth + 5'h01;
            cur_kind <= sic_pkg::SIC_MOD;
            cur_routine <= {2'b00, prio_idx}; // [R9]
         end
      end
   end

   // Busy flags end when the routine that raised them returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_busy <= 1'b0;
         sch_busy <= 1'b0;
      end else if (start_sched) begin
         sch_busy <= 1'b1;
      end else if (start_mod) begin
         mod_busy <= 1'b1; // [R21]
      end else if (wr_ret && !ret_err) begin
         case (cur_kind)
            sic_pkg::SIC_MOD: begin
               mod_busy <= 1'b0; // [R21]
            end
            sic_pkg::SIC_SCHED: begin
               sch_busy <= 1'b0;
            end
            default: ;
         endcase
      end
   end
endmodule // sic_top

// *** tb/sic_top_sva.sv ***
// Port checker for the subroutine and interrupt controller
`timescale 1ns/1ps
module sic_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [63:0] module_in,
   input wire logic [15:0] seq_pc,
   input wire logic error_flag,
   input wire logic [6:0] cur_routine,
   input wire logic int_dispatch
);
   logic wr_done;
   logic wr_call;
   // A write commits only at the pready edge
   assign wr_done = psel && penable && pready && pwrite;
   assign wr_call = wr_done && paddr == sic_pkg::OFS_CALL && pwdata[31];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_err_hold;
      error_flag && !(wr_done && paddr == sic_pkg::OFS_ERRCLR) |=> error_flag;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag dropped without clear");
   property p_call_blocked;
      wr_call && error_flag |=> $stable(cur_routine);
   endproperty
   a_call_blocked: assert property (p_call_blocked) else $error("call ran while error set");
   property p_call_enter;
      logic [6:0] n;
      (wr_call && !error_flag, n = pwdata[22:16]) |=> error_flag || cur_routine == n;
   endproperty
   a_call_enter: assert property (p_call_enter) else $error("call did not enter routine");
   property p_self_call;
      wr_call && cur_routine != 7'h00 && pwdata[22:16] == cur_routine |=> error_flag;
   endproperty
   a_self_call: assert property (p_self_call) else $error("self call not flagged");
   property p_num_err;
      wr_call && pwdata[22:16] > sic_pkg::MAX_ROUTINE |=> error_flag;
   endproperty
   a_num_err: assert property (p_num_err) else $error("call number above range not flagged");
   property p_def_err;
      wr_done && paddr == sic_pkg::OFS_DEFINE && pwdata[6:0] > sic_pkg::MAX_ROUTINE |=> error_flag;
   endproperty
   a_def_err: assert property (p_def_err) else $error("define above range not flagged");
   property p_ctl_err;
      wr_done && paddr == sic_pkg::OFS_INTCTL && (pwdata[18:16] > 3'h4 || pwdata[21:20] == 2'h3) |=> error_flag;
   endproperty
   a_ctl_err: assert property (p_ctl_err) else $error("bad control word not flagged");
   property p_disp_num;
      int_dispatch |-> cur_routine <= 7'd31 || cur_routine == sic_pkg::SCHED_ROUTINE;
   endproperty
   a_disp_num: assert property (p_disp_num) else $error("interrupt entered a wrong routine");
   c_call: cover property (wr_call);
   c_sched: cover property (int_dispatch && cur_routine == sic_pkg::SCHED_ROUTINE);
   c_err: cover property ($rose(error_flag));
endmodule // sic_top_sva

bind sic_top sic_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .module_in(module_in), .seq_pc(seq_pc), .error_flag(error_flag), .cur_routine(cur_routine),
   .int_dispatch(int_dispatch));

// *** tb/sic_partner.sv ***
// Interrupt input modules and program sequencer model
`timescale 1ns/1ps
module sic_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [31:0] pins,
   output logic [63:0] module_in,
   output logic [15:0] seq_pc
);
   logic [7:0] noise;
   // Sequencer steps one address a cycle, so every return point differs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_pc <= 16'h0100;
         noise <= 8'h5a;
      end else begin
         seq_pc <= seq_pc + 16'h0001;
         noise <= ~noise + 8'h01;
      end
   end
   // Unused upper pins carry noise, six of each eight toggling every cycle; a request from them would be a fault
   always_comb begin
      for (int m = 0; m < 4; m++) begin
         module_in[16*m +: 16] = {noise, pins[8*m +: 8]};
      end
   end
endmodule // sic_partner

// *** tb/subroutine_interrupt_control_bench.sv ***
// Self-checking bench for the subroutine and interrupt controller
`timescale 1ns/1ps
module subroutine_interrupt_control_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, error_flag, int_dispatch, last_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, pins;
   logic [63:0] module_in;
   logic [15:0] seq_pc, last_pc, pc_a, pc_b;
   logic [6:0] cur_routine;
   int n_errors, cmp_count;
   sic_top #(.TICK_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .module_in(module_in), .seq_pc(seq_pc), .error_flag(error_flag), .cur_routine(cur_routine),
      .int_dispatch(int_dispatch));
   sic_partner u_partner (.pclk(pclk), .presetn(presetn), .pins(pins), .module_in(module_in), .seq_pc(seq_pc));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task report_and_stop;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; answer and return point are taken at the pready edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         report_and_stop();
      end
      rd = prdata;
      last_err = pslverr;
      last_pc = seq_pc;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rdck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask
   // A refused write must flag the error, which is then cleared
   task bad_wr(input logic [7:0] a, input logic [31:0] d);
      wr(a, d);
      rdck(sic_pkg::OFS_STATUS, 32'h1, 32'h1);
      wr(sic_pkg::OFS_ERRCLR, 32'h0);
   endtask
   task wait_disp(input logic [6:0] n);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (int_dispatch !== 1'b1 && k < 200);
      if (int_dispatch !== 1'b1) begin
         n_errors++;
         report_and_stop();
      end
      chk(32'(cur_routine), 32'(n));
   endtask
   task no_disp(input int n);
      logic hit;
      hit = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         if (int_dispatch !== 1'b0) hit = 1'b1;
      end
      chk(32'(hit), 32'h0);
   endtask
   task pulse(input logic [31:0] v);
      @(posedge pclk);
      pins <= v;
      repeat (4) @(posedge pclk);
      pins <= 32'h0;
      repeat (4) @(posedge pclk);
   endtask
   function automatic logic [31:0] ictl(input logic [2:0] d, input logic [1:0] c, input logic im, input logic [15:0] v);
      ictl = {7'h0, im, 2'h0, c, 1'h0, d, v};
   endfunction
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pins = 32'h0;
      n_errors = 0;
      cmp_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state, then an unmapped place
      rdck(sic_pkg::OFS_STATUS, 32'hffffffff, 32'h00004000);
      rdck(sic_pkg::OFS_MASK, 32'hffffffff, 32'hffffffff);
      xfer(1'b0, 8'h30, 32'h0);
      chk(32'(last_err), 32'h1);
      $display("test reset done");
      // Nested calls, refused calls and returns
      wr(sic_pkg::OFS_DEFINE, 32'h00000105);
      wr(sic_pkg::OFS_DEFINE, 32'h00000107);
      wr(sic_pkg::OFS_CALL, 32'h80050000);
      pc_a = last_pc;
      chk(32'(cur_routine), 32'd5);
      wr(sic_pkg::OFS_CALL, 32'h80070000);
      pc_b = last_pc;
      rdck(sic_pkg::OFS_STATUS, 32'h7c, 32'h08);
      wr(sic_pkg::OFS_CALL, 32'h00050000);
      chk(32'(cur_routine), 32'd7);
      wr(sic_pkg::OFS_CALL, 32'h80070000);
      rdck(sic_pkg::OFS_STATUS, 32'h1, 32'h1);
      wr(sic_pkg::OFS_CALL, 32'h80050000);
      chk(32'(cur_routine), 32'd7);
      wr(sic_pkg::OFS_ERRCLR, 32'h0);
      wr(sic_pkg::OFS_RET, 32'h0);
      chk(32'(cur_routine), 32'd5);
      rdck(sic_pkg::OFS_RESUME, 32'hffff, 32'(pc_b));
      wr(sic_pkg::OFS_RET, 32'h0);
      rdck(sic_pkg::OFS_RESUME, 32'hffff, 32'(pc_a));
      bad_wr(sic_pkg::OFS_CALL, 32'h80090000);
      bad_wr(sic_pkg::OFS_CALL, 32'h80640000);
      bad_wr(sic_pkg::OFS_DEFINE, 32'h00000164);
      for (int i = 0; i < 16; i++) wr(sic_pkg::OFS_CALL, i[0] ? 32'h80070000 : 32'h80050000);
      rdck(sic_pkg::OFS_STATUS, 32'h7d, 32'h40);
      bad_wr(sic_pkg::OFS_CALL, 32'h80050000);
      for (int i = 0; i < 16; i++) wr(sic_pkg::OFS_RET, 32'h0);
      rdck(sic_pkg::OFS_STATUS, 32'h3fffd, 32'h04000);
      $display("test calls done");
      // Module requests: latched while masked, lowest first, no overlap, clear
      pulse(32'h00020500);
      rdck(sic_pkg::OFS_PENDING, 32'hffffffff, 32'h00020500);
      wr(sic_pkg::OFS_INTCTL, ictl(3'h1, 2'h0, 1'b0, 16'h00fa));
      wait_disp(7'd8);
      no_disp(20);
      wr(sic_pkg::OFS_INTCTL, ictl(3'h1, 2'h2, 1'b0, 16'h0));
      rdck(sic_pkg::OFS_RESULT, 32'hff, 32'hfa);
      wr(sic_pkg::OFS_RET, 32'h0);
      wait_disp(7'd10);
      wr(sic_pkg::OFS_RET, 32'h0);
      wr(sic_pkg::OFS_INTCTL, ictl(3'h2, 2'h1, 1'b0, 16'h0002));
      wr(sic_pkg::OFS_INTCTL, ictl(3'h2, 2'h0, 1'b0, 16'h0000));
      no_disp(20);
      rdck(sic_pkg::OFS_PENDING, 32'hffffffff, 32'h0);
      bad_wr(sic_pkg::OFS_INTCTL, ictl(3'h5, 2'h0, 1'b0, 16'h0));
      bad_wr(sic_pkg::OFS_INTCTL, ictl(3'h0, 2'h3, 1'b0, 16'h0));
      bad_wr(sic_pkg::OFS_INTCTL, ictl(3'h0, 2'h2, 1'b1, 16'h0));
      bad_wr(sic_pkg::OFS_INTCTL, ictl(3'h4, 2'h1, 1'b0, 16'h00a0));
      $display("test module interrupts done");
      // Scheduled interrupt preempts module routine 0, repeats, then is held off and disabled
      pulse(32'h00000001);
      wr(sic_pkg::OFS_INTCTL, ictl(3'h0, 2'h0, 1'b0, 16'h00fe));
      wait_disp(7'd0);
      wr(sic_pkg::OFS_INTCTL, ictl(3'h4, 2'h0, 1'b0, 16'h0010));
      wr(sic_pkg::OFS_INTCTL, ictl(3'h4, 2'h2, 1'b0, 16'h0));
      rdck(sic_pkg::OFS_RESULT, 32'hffff, 32'h0010);
      wr(sic_pkg::OFS_INTCTL, ictl(3'h4, 2'h1, 1'b0, 16'h0002));
      wait_disp(7'd99);
      rdck(sic_pkg::OFS_STATUS, 32'h3c000, 32'h20000);
      wr(sic_pkg::OFS_RET, 32'h0);
      rdck(sic_pkg::OFS_STATUS, 32'h3c000, 32'h10000);
      wait_disp(7'd99);
      wr(sic_pkg::OFS_RET, 32'h0);
      repeat (6) wr(sic_pkg::OFS_INTCTL, ictl(3'h4, 2'h1, 1'b0, 16'h0002));
      wr(sic_pkg::OFS_INTCTL, ictl(3'h4, 2'h1, 1'b0, 16'h0000));
      chk(32'(cur_routine), 32'd0);
      no_disp(60);
      wr(sic_pkg::OFS_RET, 32'h0);
      rdck(sic_pkg::OFS_STATUS, 32'h3fffd, 32'h04000);
      $display("test scheduled interrupt done");
      report_and_stop();
   end
endmodule // subroutine_interrupt_control_bench
